// *** rtl/afb_pkg.sv ***
// Package for the parallel host port: modes, widths, pin polarities and FIFO sizing.
// Assumes a single 100 MHz clock domain and a synchronous active-high reset.
package afb_pkg;
	// Data path width and FIFO depth
	localparam int unsigned DATA_W     = 8;
	localparam int unsigned FIFO_DEPTH = 16;
	// Clock period in ns, for derived counts
	localparam int unsigned CLK_PERIOD_NS = 10;
	// Width of the bit-bang write-indication low pulse, in ns and cycles
	localparam int unsigned WR_IND_NS     = 20;
	localparam int unsigned WR_IND_CYC    = (WR_IND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0]  WR_IND_CYC_W  = 4'(WR_IND_CYC);
	// Idle (inactive) level of active-low pins
	localparam logic        PIN_IDLE      = 1'b1;
	// Output enable level while driving (low = driving)
	localparam logic        OE_DRIVE      = 1'b0;
	localparam logic        OE_RELEASE    = 1'b1;
	// Interface modes, chosen from configuration memory or host command
	typedef enum logic [1:0] {
		AFB_MODE_IDLE,
		AFB_MODE_ASYNC_FIFO,
		AFB_MODE_BITBANG
	} afb_mode_t;
endpackage

// *** rtl/afb_fifo_if.sv ***
// Carrier for one valid/ready byte stream between the port and its FIFO.
// Assumes both sides sit on the same clock.
`timescale 1ns/1ps
interface afb_fifo_if;
	// Fill side
	logic [afb_pkg::DATA_W-1:0] in_data;
	logic                       in_valid;
	logic                       in_ready;
	// Drain side
	logic [afb_pkg::DATA_W-1:0] out_data;
	logic                       out_valid;
	logic                       out_ready;
	// Producer view of the FIFO
	modport fill  (output in_data, output in_valid, input in_ready);
	// Consumer view of the FIFO
	modport drain (input out_data, input out_valid, output out_ready);
	// The FIFO itself
	modport store (input in_data, input in_valid, output in_ready,
	               output out_data, output out_valid, input out_ready);
endinterface

// *** rtl/afb_fifo.sv ***
// Synchronous byte FIFO with valid/ready on both sides, flip-flop storage.
// Assumes one clock; full refuses fills, empty withholds valid.
`timescale 1ns/1ps
module afb_fifo #(
	parameter int unsigned WIDTH = afb_pkg::DATA_W,
	parameter int unsigned DEPTH = afb_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Stream ports
	afb_fifo_if.store q
);
	localparam int unsigned AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;   // Storage entries
		logic [AW-1:0]               wr;    // Write index
		logic [AW-1:0]               rd;    // Read index
		logic [AW:0]                 count; // Words held
	} afb_fifo_st_t;

	afb_fifo_st_t st;
	afb_fifo_st_t next_st;
	logic         push;
	logic         pop;

	// Honest flags straight from the word count
	assign q.in_ready  = (st.count != (AW+1)'(DEPTH));
	assign q.out_valid = (st.count != '0);
	assign q.out_data  = st.mem[st.rd];
	assign push        = q.in_valid && q.in_ready;
	assign pop         = q.out_valid && q.out_ready;

	// Next-state: pointers wrap at the depth
	always_comb begin
		next_st = st;
		if (push) begin
			next_st.mem[st.wr] = q.in_data;
			next_st.wr         = (st.wr == AW'(DEPTH-1)) ? '0 : st.wr + 1'b1;
		end
		if (pop) begin
			next_st.rd = (st.rd == AW'(DEPTH-1)) ? '0 : st.rd + 1'b1;
		end
		next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
	end

	// State register; reset clears the whole record, contents included
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st       <= '0;
		end else begin
			st       <= next_st;
		end
	end
endmodule

// *** rtl/afb_port.sv ***
// Parallel host port: asynchronous FIFO mode and bit-bang mode on one 8-bit bus.
// Assumes the USB engine sits on the user side with valid/ready streams, same clock.
// Strobe pin inputs arrive asynchronous and are resynchronised here; the data bus is sampled directly.
// Every strobe is acted on two cycles late, so each strobe level must stand
// for at least two clock cycles; shorter pulses may be missed.
// In FIFO mode the transmit side takes one byte more than the FIFO depth,
// since the stream output register holds a byte of its own.
`timescale 1ns/1ps
module afb_port (
	// Clock and reset
	input  wire logic                         clk_i,
	input  wire logic                         rst_i,
	// Configuration
	input  wire logic                         cfg_async_fifo_i,
	input  wire logic                         cfg_remote_wake_i,
	input  wire logic                         mode_select_command_i,
	input  wire logic                         mode_select_valid_i,
	input  wire logic                         bus_suspended_flag_i,
	// Parallel pins
	input  wire logic [afb_pkg::DATA_W-1:0]   parallel_data_bus_i,
	output logic      [afb_pkg::DATA_W-1:0]   parallel_data_bus_o,
	output logic      [afb_pkg::DATA_W-1:0]   parallel_data_bus_oe_n_o,
	input  wire logic                         rd_n_i,
	input  wire logic                         wr_n_i,
	input  wire logic                         flush_wake_n_i,
	output logic                              rx_avail_n_o,
	output logic                              rx_avail_oe_n_o,
	output logic                              tx_room_n_o,
	output logic                              tx_room_oe_n_o,
	output logic                              out_update_pulse_n_o,
	output logic                              in_sample_pulse_o,
	// Receive stream from USB side (host to pins)
	input  wire logic [afb_pkg::DATA_W-1:0]   rx_data_i,
	input  wire logic                         rx_valid_i,
	output logic                              rx_ready_o,
	// Transmit stream to USB side (pins to host)
	output logic      [afb_pkg::DATA_W-1:0]   tx_data_o,
	output logic                              tx_valid_o,
	input  wire logic                         tx_ready_i,
	// Bit-bang host requests
	input  wire logic [afb_pkg::DATA_W-1:0]   bb_out_data_i,
	input  wire logic [afb_pkg::DATA_W-1:0]   bb_dir_out_i,
	input  wire logic                         bb_write_i,
	input  wire logic                         bb_read_i,
	output logic      [afb_pkg::DATA_W-1:0]   bb_in_data_o,
	output logic                              bb_in_valid_o,
	// USB engine requests
	output logic                              resume_req_o,
	output logic                              flush_req_o
);
	localparam int unsigned W = afb_pkg::DATA_W;

	// Two FIFOs: receive (USB to pins) and transmit (pins to USB)
	afb_fifo_if rxq ();
	afb_fifo_if txq ();

	// All module state in one record
	typedef struct packed {
		afb_pkg::afb_mode_t mode;      // Active interface mode
		logic [2:0]         rd_s;      // Read strobe sync and history
		logic [2:0]         wr_s;      // Write strobe sync and history
		logic [2:0]         fw_s;      // Flush/wake sync and history
		logic [W-1:0]       dout;      // Byte driven on the bus
		logic [W-1:0]       oe_n;      // Per-line output enable, low drives
		logic               rxf_n;     // Receive-available flag
		logic               rxf_oe_n;  // Flag pin enable
		logic               txe_n;     // Transmit-room flag
		logic               txe_oe_n;  // Flag pin enable
		logic               pop;       // Advance receive FIFO
		logic               push;      // Capture into transmit FIFO
		logic [W-1:0]       cap;       // Captured bus byte
		logic [3:0]         wr_cnt;    // Write indication width count
		logic               wr_ind_n;  // Write indication output
		logic               rd_ind;    // Read indication output
		logic [W-1:0]       bb_in;     // Sampled bit-bang value
		logic               bb_in_v;   // Sample valid pulse
		logic               resume;    // Resume request pulse
		logic               flush;     // Flush request pulse
		logic               rx_rdy;    // Receive stream ready
		logic [W-1:0]       tx_d;      // Transmit stream data
		logic               tx_v;      // Transmit stream valid
	} afb_port_st_t;

	afb_port_st_t st;
	afb_port_st_t next_st;
	logic         rd_fall;
	logic         rd_rise;
	logic         wr_fall;
	logic         fw_fall;

	// Edges seen only on the second and third stages, never the first
	assign rd_fall = st.rd_s[2] && !st.rd_s[1];
	assign rd_rise = !st.rd_s[2] && st.rd_s[1];
	assign wr_fall = st.wr_s[2] && !st.wr_s[1];
	assign fw_fall = st.fw_s[2] && !st.fw_s[1];

	// Receive FIFO: filled from USB side, drained by read strobes
	assign rxq.in_data   = rx_data_i;
	assign rxq.in_valid  = rx_valid_i && st.rx_rdy;
	assign rxq.out_ready = st.pop;
	// Transmit FIFO: filled by write strobes, drained to USB side
	assign txq.in_data   = st.cap;
	assign txq.in_valid  = st.push;
	assign txq.out_ready = !st.tx_v || tx_ready_i;

	afb_fifo #(.WIDTH(W), .DEPTH(afb_pkg::FIFO_DEPTH)) u_rx_fifo (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.q     (rxq.store)
	);

	afb_fifo #(.WIDTH(W), .DEPTH(afb_pkg::FIFO_DEPTH)) u_tx_fifo (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.q     (txq.store)
	);

	// Next-state logic for both modes
	always_comb begin
		next_st         = st;
		next_st.rd_s    = {st.rd_s[1:0], rd_n_i};
		next_st.wr_s    = {st.wr_s[1:0], wr_n_i};
		next_st.fw_s    = {st.fw_s[1:0], flush_wake_n_i};
		// One-cycle pulses default low
		next_st.pop     = 1'b0;
		next_st.push    = 1'b0;
		next_st.bb_in_v = 1'b0;
		next_st.resume  = 1'b0;
		next_st.flush   = 1'b0;
		next_st.rd_ind  = 1'b0;
		// Flags are driven in FIFO and bit-bang modes; idle mode releases them
		next_st.rxf_oe_n = afb_pkg::OE_DRIVE;
		next_st.txe_oe_n = afb_pkg::OE_DRIVE;
		// Ready is registered, so it is granted only after a cycle with no fill in flight;
		// the room it was drawn from is then still current at the next edge.
		// This halves the fill rate but never promises room that a push just took.
		next_st.rx_rdy   = rxq.in_ready && !rxq.in_valid;

		// Mode selection: configuration memory, then host command
		// configuration picks FIFO mode
		if (mode_select_valid_i) begin
			if (mode_select_command_i) begin
				next_st.mode = afb_pkg::AFB_MODE_BITBANG;
			end else if (cfg_async_fifo_i) begin
				next_st.mode = afb_pkg::AFB_MODE_ASYNC_FIFO;
			end else begin
				next_st.mode = afb_pkg::AFB_MODE_IDLE;
			end
		end

		// Transmit stream output register, refilled when taken
		// It holds one byte beyond the FIFO, which the room flag does not count
		if (txq.out_ready) begin
			next_st.tx_v = txq.out_valid;
			next_st.tx_d = txq.out_data;
		end

		case (st.mode)
			afb_pkg::AFB_MODE_ASYNC_FIFO: begin
				// all transfers keyed to strobe edges
				next_st.wr_cnt   = '0;
				next_st.wr_ind_n = afb_pkg::PIN_IDLE;
				// drive bus only while read low
				// present current byte on read fall
				// A read taken while the flag was high never drives, so it never pops
				if (rd_fall && !st.rxf_n) begin
					next_st.dout = rxq.out_data;
					next_st.oe_n = {W{afb_pkg::OE_DRIVE}};
				end
				// Release follows the synchronised strobe, two cycles after the pin
				if (st.rd_s[1]) begin
					next_st.oe_n = {W{afb_pkg::OE_RELEASE}};
				end
				// flag forced high after each read
				// Only a read that drove the bus consumes a byte
				if (rd_rise && st.oe_n == {W{afb_pkg::OE_DRIVE}}) begin
					next_st.pop   = 1'b1;
					next_st.rxf_n = afb_pkg::PIN_IDLE;
				end else if (!st.pop && st.rd_s[1] && !rd_rise) begin
					// low only with a byte waiting
					next_st.rxf_n = !rxq.out_valid;
				end
				// capture bus byte on write fall
				if (wr_fall && !st.txe_n) begin
					next_st.cap  = parallel_data_bus_i;
					next_st.push = 1'b1;
				end
				next_st.txe_n = !(txq.in_ready && !st.push && !next_st.push);
			end
			afb_pkg::AFB_MODE_BITBANG: begin
				next_st.rxf_n = afb_pkg::PIN_IDLE;
				next_st.txe_n = afb_pkg::PIN_IDLE;
				// per-bit direction from the host
				// Direction bit high means output, so its enable goes low;
				// input lines stay released and never fight the outside party
				next_st.oe_n  = ~bb_dir_out_i;
				// low pulse after each host update
				if (bb_write_i) begin
					next_st.dout     = bb_out_data_i;
					next_st.wr_cnt   = afb_pkg::WR_IND_CYC_W;
					next_st.wr_ind_n = 1'b0;
				end else if (st.wr_cnt > 4'h1) begin
					next_st.wr_cnt   = st.wr_cnt - 4'h1;
				end else begin
					next_st.wr_cnt   = '0;
					next_st.wr_ind_n = afb_pkg::PIN_IDLE;
				end
				if (bb_read_i) begin
					next_st.bb_in   = parallel_data_bus_i;
					next_st.bb_in_v = 1'b1;
					next_st.rd_ind  = 1'b1;
				end
			end
			default: begin
				// Idle: bus and flag pins released, flags left to their pull-ups
				next_st.oe_n     = {W{afb_pkg::OE_RELEASE}};
				next_st.rxf_oe_n = afb_pkg::OE_RELEASE;
				next_st.txe_oe_n = afb_pkg::OE_RELEASE;
				next_st.rxf_n    = afb_pkg::PIN_IDLE;
				next_st.txe_n    = afb_pkg::PIN_IDLE;
				next_st.wr_ind_n = afb_pkg::PIN_IDLE;
				next_st.wr_cnt   = '0;
			end
		endcase

		// Shared flush/wake input, any active mode
		// Idle mode ignores it, so a floating pin cannot wake the host
		if (fw_fall && st.mode != afb_pkg::AFB_MODE_IDLE) begin
			if (bus_suspended_flag_i) begin
				next_st.resume = cfg_remote_wake_i;
			end else begin
				next_st.flush  = 1'b1;
			end
		end
	end

	// State register
	// Synchronous reset; flag pins stay released while it is held
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st          <= '0;
			st.mode     <= afb_pkg::AFB_MODE_IDLE;
			st.rd_s     <= '1;
			st.wr_s     <= '1;
			st.fw_s     <= '1;
			st.oe_n     <= {W{afb_pkg::OE_RELEASE}};
			st.rxf_n    <= afb_pkg::PIN_IDLE;
			st.rxf_oe_n <= afb_pkg::OE_RELEASE;
			st.txe_n    <= afb_pkg::PIN_IDLE;
			st.txe_oe_n <= afb_pkg::OE_RELEASE;
			st.wr_ind_n <= afb_pkg::PIN_IDLE;
			st.tx_v     <= 1'b0;
		end else begin
			st          <= next_st;
		end
	end

	// Outputs straight from state flip-flops
	assign parallel_data_bus_o      = st.dout;
	// bit-bang enables per host direction when output
	assign parallel_data_bus_oe_n_o = st.oe_n;
	assign rx_avail_n_o             = st.rxf_n;
	assign rx_avail_oe_n_o          = st.rxf_oe_n;
	assign tx_room_n_o              = st.txe_n;
	assign tx_room_oe_n_o           = st.txe_oe_n;
	assign out_update_pulse_n_o     = st.wr_ind_n;
	assign in_sample_pulse_o        = st.rd_ind;
	assign rx_ready_o               = st.rx_rdy;
	assign tx_data_o                = st.tx_d;
	assign tx_valid_o               = st.tx_v;
	assign bb_in_data_o             = st.bb_in;
	assign bb_in_valid_o            = st.bb_in_v;
	assign resume_req_o             = st.resume;
	assign flush_req_o              = st.flush;
endmodule

// *** bench/afb_host_model.sv ***
// Outside controller on the parallel pins, with resolution of the shared bus.
// Assumes the device answers each strobe within a few clock cycles.
`timescale 1ns/1ps
module afb_host_model (
	// Clock
	input  wire logic       clk_i,
	// Device side of the pins
	input  wire logic [7:0] dev_data_i,
	input  wire logic [7:0] dev_oe_n_i,
	input  wire logic       rx_avail_n_i,
	input  wire logic       tx_room_n_i,
	// Pins driven by the controller
	output logic      [7:0] bus_o,
	output logic            rd_n_o,
	output logic            wr_n_o
);
	logic       drv = 1'b0;  // Controller drives the bus
	logic [7:0] val = 8'h00; // Value it drives
	logic [7:0] last = 8'h00; // Undriven bus shows the inverse, so stale data never matches
	initial rd_n_o = 1'b1;
	initial wr_n_o = 1'b1;
	// Bus level from both parties
	// Per line: an enable at zero means the device drives that line
	always_comb bus_o = (dev_data_i & ~dev_oe_n_i) | ((drv ? val : ~last) & dev_oe_n_i);
	always @(posedge clk_i) last <= bus_o;
	// Drive or release the bus for bit-bang input
	task automatic drive(input logic on, input logic [7:0] v);
		drv <= on;
		val <= v;
	endtask
	task automatic rd(output logic [7:0] d, output logic ok);
		int i;
		d = 8'h00;
		@(negedge clk_i);
		for (i = 0; i < 40 && rx_avail_n_i !== 1'b0; i++) @(negedge clk_i);
		ok = (rx_avail_n_i === 1'b0);
		if (ok) begin
			@(posedge clk_i) rd_n_o <= 1'b0;
			repeat (6) @(negedge clk_i);
			d = bus_o;
			@(posedge clk_i) rd_n_o <= 1'b1;
			repeat (6) @(posedge clk_i);
		end
	endtask
	// write while room low, strobe falls
	task automatic wr(input logic [7:0] v, output logic ok);
		int i;
		@(negedge clk_i);
		for (i = 0; i < 40 && tx_room_n_i !== 1'b0; i++) @(negedge clk_i);
		ok = (tx_room_n_i === 1'b0);
		if (ok) begin
			@(posedge clk_i);
			drive(1'b1, v);
			wr_n_o <= 1'b0;
			repeat (6) @(posedge clk_i);
			wr_n_o <= 1'b1;
			repeat (2) @(posedge clk_i);
			drive(1'b0, 8'h00);
			repeat (4) @(posedge clk_i);
		end
	endtask
endmodule

// *** bench/afb_port_monitor.sv ***
// Checker on the port's pins and requests, bound to the port.
// Assumes one clock and that the mode inputs pulse valid for one cycle.
`timescale 1ns/1ps
module afb_port_monitor (
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       cfg_async_fifo_i,
	input wire logic       cfg_remote_wake_i,
	input wire logic       mode_select_command_i,
	input wire logic       mode_select_valid_i,
	input wire logic       bus_suspended_flag_i,
	input wire logic       rd_n_i,
	input wire logic       wr_n_i,
	input wire logic       flush_wake_n_i,
	input wire logic [7:0] parallel_data_bus_oe_n_o,
	input wire logic       rx_avail_n_o,
	input wire logic       rx_avail_oe_n_o,
	input wire logic       tx_room_n_o,
	input wire logic       tx_room_oe_n_o,
	input wire logic       out_update_pulse_n_o,
	input wire logic       in_sample_pulse_o,
	input wire logic       tx_valid_o,
	input wire logic       bb_read_i,
	input wire logic       bb_write_i,
	input wire logic       resume_req_o,
	input wire logic       flush_req_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [1:0] mode; // Followed mode: 0 idle, 1 FIFO, 2 bit-bang
	// Mode tracking from the select inputs
	always_ff @(posedge clk_i) begin
		if (rst_i) mode <= 2'h0;
		else if (mode_select_valid_i) mode <= mode_select_command_i ? 2'h2 : {1'b0, cfg_async_fifo_i};
	end
	// Write indication is low for exactly two cycles
	sequence s_low2;
		!out_update_pulse_n_o ##1 out_update_pulse_n_o;
	endsequence
	property p_rst_flags;
		disable iff (1'b0) rst_i |=> rx_avail_oe_n_o == afb_pkg::OE_RELEASE && tx_room_oe_n_o == afb_pkg::OE_RELEASE;
	endproperty
	property p_bus_idle;
		(mode == 2'h1 && rd_n_i) [*5] |-> parallel_data_bus_oe_n_o == {8{afb_pkg::OE_RELEASE}};
	endproperty
	property p_rd_rise;
		mode == 2'h1 && $rose(rd_n_i) |-> ##[1:4] rx_avail_n_o;
	endproperty
	property p_rd_fall;
		mode == 2'h1 && $fell(rd_n_i) && !rx_avail_n_o |-> ##[1:4] parallel_data_bus_oe_n_o == {8{afb_pkg::OE_DRIVE}};
	endproperty
	property p_wr_fall;
		mode == 2'h1 && $fell(wr_n_i) && !tx_room_n_o |-> ##[1:8] tx_valid_o;
	endproperty
	property p_sync;
		$fell(rd_n_i) && parallel_data_bus_oe_n_o == {8{afb_pkg::OE_RELEASE}}
			|=> parallel_data_bus_oe_n_o == {8{afb_pkg::OE_RELEASE}};
	endproperty
	property p_resume;
		mode != 2'h0 && $fell(flush_wake_n_i) && bus_suspended_flag_i && cfg_remote_wake_i |-> ##[1:8] resume_req_o;
	endproperty
	property p_flush;
		mode != 2'h0 && $fell(flush_wake_n_i) && !bus_suspended_flag_i |-> ##[1:8] flush_req_o;
	endproperty
	property p_upd;
		$fell(out_update_pulse_n_o) |=> s_low2;
	endproperty
	property p_sample;
		mode == 2'h2 && bb_read_i |-> ##[1:6] $rose(in_sample_pulse_o);
	endproperty
	a_rst_flags: assert property (p_rst_flags) else $error("flags not released in reset");
	a_bus_idle: assert property (p_bus_idle) else $error("bus driven with read strobe high");
	a_rd_rise: assert property (p_rd_rise) else $error("receive flag not raised after read");
	a_rd_fall: assert property (p_rd_fall) else $error("bus not driven on read");
	a_wr_fall: assert property (p_wr_fall) else $error("written byte not forwarded");
	a_sync: assert property (p_sync) else $error("read strobe acted on unsynchronised");
	a_resume: assert property (p_resume) else $error("no resume request");
	a_flush: assert property (p_flush) else $error("no flush request");
	a_upd: assert property (p_upd) else $error("write indication width wrong");
	a_sample: assert property (p_sample) else $error("read indication did not rise");
endmodule
bind afb_port afb_port_monitor u_mon (.clk_i, .rst_i, .cfg_async_fifo_i, .cfg_remote_wake_i, .mode_select_command_i,
	.mode_select_valid_i, .bus_suspended_flag_i, .rd_n_i, .wr_n_i, .flush_wake_n_i, .parallel_data_bus_oe_n_o,
	.rx_avail_n_o, .rx_avail_oe_n_o, .tx_room_n_o, .tx_room_oe_n_o, .out_update_pulse_n_o, .in_sample_pulse_o,
	.tx_valid_o, .bb_read_i, .bb_write_i, .resume_req_o, .flush_req_o);

// *** bench/afb_port_tb.sv ***
// Testbench for the parallel host port: FIFO mode, bit-bang, flush and wake.
// Assumes the controller model and the bound checker are compiled before it.
`timescale 1ns/1ps
module afb_port_tb;
	logic       clk_i = 1'b0, rst_i = 1'b1, cfg_async_fifo_i = 1'b0, cfg_remote_wake_i = 1'b0;
	logic       bus_suspended_flag_i = 1'b0, mode_select_command_i = 1'b0, mode_select_valid_i = 1'b0;
	logic [7:0] parallel_data_bus_i, parallel_data_bus_o, rx_data_i = 8'h00, tx_data_o, bb_in_data_o;
	logic [7:0] bb_out_data_i = 8'h00, bb_dir_out_i = 8'h00, parallel_data_bus_oe_n_o;
	logic       rd_n_i, wr_n_i, rx_avail_n_o, rx_avail_oe_n_o, tx_room_n_o;
	logic       tx_room_oe_n_o, out_update_pulse_n_o, in_sample_pulse_o, rx_ready_o, tx_valid_o;
	logic       rx_valid_i = 1'b0, tx_ready_i = 1'b1, bb_write_i = 1'b0, bb_read_i = 1'b0;
	logic       bb_in_valid_o, resume_req_o, flush_req_o;
	logic       flush_wake_n_i = 1'b1;
	int         errors = 0, n_tests = 0;
	// Each entry: suspended, wake enabled, resume expected, flush expected
	localparam logic [3:0] WAKE_TAB [3] = '{4'h5, 4'hE, 4'h8};
	always #5 clk_i = ~clk_i;
	afb_port u_dut (.clk_i, .rst_i, .cfg_async_fifo_i, .cfg_remote_wake_i, .mode_select_command_i,
		.mode_select_valid_i, .bus_suspended_flag_i, .parallel_data_bus_i, .parallel_data_bus_o,
		.parallel_data_bus_oe_n_o, .rd_n_i, .wr_n_i, .flush_wake_n_i, .rx_avail_n_o, .rx_avail_oe_n_o, .tx_room_n_o,
		.tx_room_oe_n_o, .out_update_pulse_n_o, .in_sample_pulse_o, .rx_data_i, .rx_valid_i, .rx_ready_o, .tx_data_o,
		.tx_valid_o, .tx_ready_i, .bb_out_data_i, .bb_dir_out_i, .bb_write_i, .bb_read_i, .bb_in_data_o,
		.bb_in_valid_o, .resume_req_o, .flush_req_o);
	afb_host_model u_host (.clk_i, .dev_data_i(parallel_data_bus_o), .dev_oe_n_i(parallel_data_bus_oe_n_o),
		.rx_avail_n_i(rx_avail_n_o), .tx_room_n_i(tx_room_n_o), .bus_o(parallel_data_bus_i), .rd_n_o(rd_n_i),
		.wr_n_o(wr_n_i));
	// Shared comparison, counts every check
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One-cycle mode request, then time to settle
	task automatic set_mode(input logic cmd, input logic cfg);
		@(posedge clk_i);
		mode_select_command_i <= cmd;
		cfg_async_fifo_i <= cfg;
		mode_select_valid_i <= 1'b1;
		@(posedge clk_i);
		mode_select_valid_i <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask
	task automatic t_reset;
		repeat (10) @(posedge clk_i);
		chk("rx flag enable", 8'(afb_pkg::OE_RELEASE), 8'(rx_avail_oe_n_o));
		chk("tx flag enable", 8'(afb_pkg::OE_RELEASE), 8'(tx_room_oe_n_o));
		rst_i <= 1'b0;
		$display("test reset done");
	endtask
	task automatic t_idle;
		set_mode(1'b0, 1'b0);
		chk("idle bus enable", {8{afb_pkg::OE_RELEASE}}, parallel_data_bus_oe_n_o);
		chk("idle rx enable", 8'(afb_pkg::OE_RELEASE), 8'(rx_avail_oe_n_o));
		$display("test idle done");
	endtask
	// Fill the receive FIFO until refused, then read every byte back over the pins
	task automatic t_rx;
		int i, n;
		logic [7:0] d;
		logic ok;
		n = 0;
		set_mode(1'b0, 1'b1);
		rx_data_i <= 8'h10;
		rx_valid_i <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge clk_i);
			if (rx_ready_o === 1'b1) n++;
			rx_data_i <= 8'(8'h10 + n);
		end
		rx_valid_i <= 1'b0;
		chk("rx depth", 8'(afb_pkg::FIFO_DEPTH), 8'(n));
		for (i = 0; i < n; i++) begin
			u_host.rd(d, ok);
			chk("rx byte", 8'(8'h10 + i), d);
		end
		repeat (8) @(negedge clk_i);
		chk("rx flag empty", 8'h01, 8'(rx_avail_n_o));
		$display("test rx done");
	endtask
	// Fill the transmit FIFO with the far side stalled, then drain it in order
	task automatic t_tx;
		int i, n, k;
		logic ok;
		n = 0;
		k = 0;
		@(posedge clk_i);
		tx_ready_i <= 1'b0;
		for (i = 0; i < 20; i++) begin
			u_host.wr(8'(8'hA0 + i), ok);
			if (!ok) break;
			n++;
		end
		// The stream output register holds one byte beyond the FIFO
		chk("tx depth", 8'(afb_pkg::FIFO_DEPTH + 1), 8'(n));
		@(posedge clk_i);
		tx_ready_i <= 1'b1;
		for (i = 0; i < 60 && k < n; i++) begin
			@(posedge clk_i);
			if (tx_valid_o === 1'b1) begin
				chk("tx byte", 8'(8'hA0 + k), tx_data_o);
				k++;
			end
		end
		chk("tx drained", 8'(n), 8'(k));
		$display("test tx done");
	endtask
	task automatic t_wake;
		int i, j;
		logic [1:0] seen;
		for (j = 0; j < 3; j++) begin
			@(posedge clk_i);
			bus_suspended_flag_i <= WAKE_TAB[j][3];
			cfg_remote_wake_i <= WAKE_TAB[j][2];
			repeat (2) @(posedge clk_i);
			seen = 2'h0;
			flush_wake_n_i <= 1'b0;
			// The request pulse comes while the input is still low; look from the start
			repeat (4) @(posedge clk_i) seen = seen | {resume_req_o, flush_req_o};
			flush_wake_n_i <= 1'b1;
			for (i = 0; i < 12; i++) begin
				@(negedge clk_i);
				seen = seen | {resume_req_o, flush_req_o};
			end
			chk("resume and flush", 8'(WAKE_TAB[j][1:0]), 8'(seen));
		end
		bus_suspended_flag_i <= 1'b0;
		$display("test wake done");
	endtask
	task automatic t_bb;
		int i;
		logic seen;
		logic [7:0] got;
		seen = 1'b0;
		got = 8'h00;
		set_mode(1'b1, 1'b0);
		bb_dir_out_i <= 8'hFF;
		bb_out_data_i <= 8'h5A;
		bb_write_i <= 1'b1;
		@(posedge clk_i);
		bb_write_i <= 1'b0;
		for (i = 0; i < 10; i++) @(negedge clk_i) seen = seen | (out_update_pulse_n_o === 1'b0);
		chk("update pulse", 8'h01, 8'(seen));
		chk("bb bus out", 8'h5A, parallel_data_bus_o);
		chk("bb bus enable", {8{afb_pkg::OE_DRIVE}}, parallel_data_bus_oe_n_o);
		@(posedge clk_i);
		bb_dir_out_i <= 8'h00;
		u_host.drive(1'b1, 8'h3C);
		// Let the line enables turn round before the pins are sampled
		@(posedge clk_i);
		bb_read_i <= 1'b1;
		@(posedge clk_i);
		bb_read_i <= 1'b0;
		for (i = 0; i < 10; i++) @(negedge clk_i) if (bb_in_valid_o === 1'b1) got = bb_in_data_o;
		chk("bb bus in", 8'h3C, got);
		chk("bb bus released", {8{afb_pkg::OE_RELEASE}}, parallel_data_bus_oe_n_o);
		u_host.drive(1'b0, 8'h00);
		$display("test bitbang done");
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Main sequence
	initial begin
		t_reset;
		t_idle;
		t_rx;
		t_tx;
		t_wake;
		t_bb;
		give_verdict;
	end
	// Watchdog well past the under one thousand cycles the tests need
	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		$display("[ERR] watchdog expected end seen hang");
		give_verdict;
	end
endmodule
